//--- bac_pkg.sv
// Package of constants, types and carriers for the burst acquisition control block
package bac_pkg;

    // ==========================================================
    // Local register bus geometry
    localparam int unsigned ADDR_W = 8;                 // Byte address width
    localparam int unsigned DATA_W = 32;                // Local bus data width

    // ==========================================================
    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_BCR  = 8'h00;    // Board control word
    localparam logic [ADDR_W-1:0] OFS_IPC  = 8'h08;    // Input port configuration
    localparam logic [ADDR_W-1:0] OFS_BLEN = 8'h1C;    // Burst length
    localparam logic [ADDR_W-1:0] OFS_TMR  = 8'h3C;    // Burst trigger timer

    // ==========================================================
    // Board control word bit positions
    localparam int unsigned BCR_SW_SYNC  = 6;           // Software sync command
    localparam int unsigned BCR_CH_READY = 13;          // Channels ready flag
    localparam int unsigned BCR_TMR_EN   = 16;          // Periodic trigger enable
    localparam int unsigned BCR_BURST_EN = 21;          // Burst mode enable
    localparam int unsigned BCR_SW_TRIG  = 22;          // Software burst trigger

    // ==========================================================
    // Field widths and reset values
    localparam int unsigned BLEN_W = 24;                // Burst length width
    localparam int unsigned TMR_W  = 24;                // Timer divisor width
    localparam int unsigned CHN_W  = 4;                 // Active channel count width
    localparam int unsigned TOT_W  = BLEN_W + CHN_W;    // Total sample count width
    localparam logic [BLEN_W-1:0] BLEN_RST = 24'h000001; // One sample set
    localparam logic [TMR_W-1:0]  TMR_RST  = 24'h00C000; // Default divisor

    // ==========================================================
    // Timing
    localparam int unsigned CLK_HZ          = 20_000_000; // Core clock rate
    localparam int unsigned CLK_PERIOD_NS   = 50;         // Core clock period
    localparam int unsigned FREF_NOMINAL_HZ = 49_152_000; // Nominal master clock
    localparam int unsigned SYNC_IN_MIN_NS  = 120;        // Least sync input pulse
    localparam int unsigned SYNC_OUT_NS     = 120;        // Trigger echo pulse
    localparam int unsigned SYNC_OUT_CYC    = (SYNC_OUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_S        = 5;          // Input settling hold
    localparam int unsigned SETTLE_CYC      = SETTLE_S * CLK_HZ;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        BST_IDLE = 2'h1,                                // Waiting for a trigger
        BST_RUN  = 2'h2                                 // Burst in progress
    } bac_burst_e;

    typedef struct packed {
        logic aux_current;                              // Factory diagnostic current
        logic line_comp;                                // Long cable compensation
        logic bias_on;                                  // Bias current sources on
        logic coupling_select;                          // 0 AC, 1 DC
    } bac_ipc_s;

    typedef struct packed {
        logic              wr;                          // Write strobe, one cycle
        logic              rd;                          // Read strobe, one cycle
        logic [ADDR_W-1:0] addr;                        // Byte address
        logic [DATA_W-1:0] wdata;                       // Write data
    } bac_lbus_s;

endpackage

//--- bac_burst_ctrl.sv
// Burst acquisition control: trigger sources, burst sequencing, input port configuration
`timescale 1ns/1ns

// Function
// R1 - Config bit 0: AC when zero, DC when one
// R2 - Config bit 1 switches bias current sources
// R3 - Config bit 2 enables long cable compensation
// R4 - Config bit 3 diagnostic current, keep zero
// R5 - Hold channels ready low five seconds
// R6 - Accepted trigger samples until count reached
// R7 - Burst length 24 bits, times active channels
// R8 - Zero length gives endless burst
// R9 - Triggers from software, timer, sync input
// R10 - External sync pulse at least 120 ns
// R11 - Software trigger bit high during burst
// R12 - Echo each trigger as 120 ns pulse; code echoes each accepted trigger for three cycles, 150 ns
// R13 - Ignore triggers while busy or buffer disabled
// R14 - Software trigger bit clears itself only
// R15 - Burst mode: sync input only triggers
// R16 - Synchronize boards before enabling burst mode
// R17 - Burst mode ignores software sync command
// R18 - Timer triggers at clock over divisor
// R19 - Master clock nominally 49.152 MHz
// R20 - Timer register at 3C, reset C000
// R21 - Timer enable is control bit 16
// R22 - Burst enable bit 21, trigger bit 22
// R23 - Burst length at 1C, reset one
// R24 - Finite burst end clears trigger bit
// R25 - Timer restarts from zero at divisor
module bac_burst_ctrl
    import bac_pkg::*;
#(
    parameter int unsigned SETTLE_CYCLES = SETTLE_CYC   // Settling hold in clock cycles
) (
    input  wire logic              core_clk_in,          // Core clock
    input  wire logic              reset_n_in,           // Asynchronous reset, active low
    input  wire bac_lbus_s         lbus_in,              // Local register bus request
    output logic [DATA_W-1:0]      rdata_out,            // Read data, one cycle after rd
    input  wire logic              buffer_enabled_in,    // Data buffer enabled
    input  wire logic              sample_tick_in,       // One sample set taken
    input  wire logic [CHN_W-1:0]  active_channels_in,   // Number of active channels
    input  wire logic              sync_in_line_in,      // External sync input pin
    output logic                   sync_out_line_out,    // External sync output pin
    output bac_ipc_s               ipc_out,              // Input port configuration
    output logic                   channels_ready_out,   // Inputs settled
    output logic                   sample_enable_out,    // Burst sampling gate
    output logic                   burst_done_out,       // Finite burst completed pulse
    output logic [TOT_W-1:0]       burst_total_out,      // Total samples per burst
    output logic                   board_sync_out        // Normal board sync request pulse
);

    localparam int unsigned SET_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SET_W-1:0] SET_LOAD = SET_W'(SETTLE_CYCLES);
    localparam logic [1:0] ECHO_LOAD = 2'(SYNC_OUT_CYC);

    // ==========================================================
    // Register file state
    logic              tmr_en_q, tmr_en_d;               // Periodic trigger enable
    logic              burst_en_q, burst_en_d;           // Burst mode enable
    bac_ipc_s          ipc_q, ipc_d;                     // Input port configuration
    logic [BLEN_W-1:0] blen_q, blen_d;                   // Burst length
    logic [TMR_W-1:0]  div_q, div_d;                     // Timer divisor
    logic [DATA_W-1:0] rdata_q, rdata_d;                 // Read data holding
    logic [TOT_W-1:0]  total_q, total_d;                 // Samples per burst, all channels
    logic              sw_trig_req;                      // Software trigger written
    logic              sw_sync_req;                      // Software sync written
    logic              bcr_wr, ipc_wr;                   // Decoded write strobes

    // Settling, timer, burst, sync state
    logic [SET_W-1:0]  set_cnt_q, set_cnt_d;             // Settling countdown
    logic              ready_q, ready_d;                 // Channels ready
    logic              settle_start;                     // Settling restart
    logic [TMR_W-1:0]  tmr_cnt_q, tmr_cnt_d;             // Timer count
    logic              tmr_pulse_q, tmr_pulse_d;         // Timer trigger
    bac_burst_e        state_q, state_d;                 // Burst sequencer
    logic [BLEN_W-1:0] cnt_q, cnt_d;                     // Sample sets taken
    logic              done_q, done_d;                   // Completion pulse
    logic              samp_en_q, samp_en_d;             // Sampling gate
    logic              accept;                           // Trigger accepted
    logic              sync1_q, sync2_q, sync3_q;        // Sync input stages
    logic              sync_edge;                        // Sync input rising edge
    logic [1:0]        echo_cnt_q, echo_cnt_d;           // Echo pulse countdown
    logic              echo_q, echo_d;                   // Echo pin level
    logic              bsync_q, bsync_d;                 // Board sync request

    assign bcr_wr      = lbus_in.wr && (lbus_in.addr == OFS_BCR);
    assign ipc_wr      = lbus_in.wr && (lbus_in.addr == OFS_IPC);
    assign sw_trig_req = bcr_wr && lbus_in.wdata[BCR_SW_TRIG];
    assign sw_sync_req = bcr_wr && lbus_in.wdata[BCR_SW_SYNC];

    // ==========================================================
    // Register writes and reads
    always_comb begin
        tmr_en_d   = tmr_en_q;
        burst_en_d = burst_en_q;
        ipc_d      = ipc_q;
        blen_d     = blen_q;
        div_d      = div_q;
        rdata_d    = rdata_q;
        // Trigger bit is not stored here; writing zero has no effect
        if (bcr_wr) begin                                                                    // R14
            tmr_en_d   = lbus_in.wdata[BCR_TMR_EN];                                          // R21
            burst_en_d = lbus_in.wdata[BCR_BURST_EN];                                        // R22
        end
        // All four bits are stored as written; the diagnostic bit is software's to keep low
        if (ipc_wr) begin
            ipc_d = bac_ipc_s'(lbus_in.wdata[3:0]);                                          // R1 R2 R3 R4
        end
        if (lbus_in.wr && (lbus_in.addr == OFS_BLEN)) begin
            blen_d = lbus_in.wdata[BLEN_W-1:0];                                              // R7 R23
        end
        if (lbus_in.wr && (lbus_in.addr == OFS_TMR)) begin
            div_d = lbus_in.wdata[TMR_W-1:0];                                                // R20
        end
        // Read answer; unmapped offsets and reserved bits give zero
        if (lbus_in.rd) begin
            rdata_d = '0;
            case (lbus_in.addr)
                OFS_BCR: begin
                    rdata_d[BCR_CH_READY] = ready_q;
                    rdata_d[BCR_TMR_EN]   = tmr_en_q;
                    rdata_d[BCR_BURST_EN] = burst_en_q;
                    rdata_d[BCR_SW_TRIG]  = (state_q == BST_RUN);                            // R11
                end
                OFS_IPC:  rdata_d[3:0] = ipc_q;
                OFS_BLEN: rdata_d[BLEN_W-1:0] = blen_q;
                OFS_TMR:  rdata_d[TMR_W-1:0] = div_q;
                default:  rdata_d = '0;
            endcase
        end
        // Product covers every active channel for the host's sample count
        total_d = TOT_W'(blen_q) * TOT_W'(active_channels_in);                              // R7
    end

    // Register file flops
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tmr_en_q   <= 1'b0;
            burst_en_q <= 1'b0;
            ipc_q      <= '0;
            blen_q     <= BLEN_RST;
            div_q      <= TMR_RST;
            rdata_q    <= '0;
            total_q    <= '0;
        end else begin
            tmr_en_q   <= tmr_en_d;
            burst_en_q <= burst_en_d;
            ipc_q      <= ipc_d;
            blen_q     <= blen_d;
            div_q      <= div_d;
            rdata_q    <= rdata_d;
            total_q    <= total_d;
        end
    end

    // ==========================================================
    // Settling hold on channels ready
    // Restart on a move into AC coupling or on bias current switched on
    assign settle_start = ipc_wr &&
                          ((ipc_q.coupling_select && !lbus_in.wdata[0]) ||
                           (!ipc_q.bias_on && lbus_in.wdata[1]));
    always_comb begin
        set_cnt_d = set_cnt_q;
        if (settle_start) begin
            set_cnt_d = SET_LOAD;                                                            // R5
        end else if (set_cnt_q != '0) begin
            set_cnt_d = set_cnt_q - SET_W'(1);
        end
        ready_d = (set_cnt_d == '0);
    end

    // Reset counts as a change, so the hold also follows reset
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            set_cnt_q <= SET_LOAD;
            ready_q   <= 1'b0;
        end else begin
            set_cnt_q <= set_cnt_d;
            ready_q   <= ready_d;
        end
    end

    // ==========================================================
    // Periodic trigger timer; the core clock stands in for the master clock                // R19
    always_comb begin
        tmr_cnt_d   = '0;
        tmr_pulse_d = 1'b0;
        // A zero divisor would mean an infinite rate, so it gives no triggers
        if (tmr_en_q && (div_q != '0)) begin
            if (tmr_cnt_q >= div_q - TMR_W'(1)) begin
                tmr_pulse_d = 1'b1;                                                          // R18
                tmr_cnt_d   = '0;                                                            // R25
            end else begin
                tmr_cnt_d = tmr_cnt_q + TMR_W'(1);                                           // R25
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tmr_cnt_q   <= '0;
            tmr_pulse_q <= 1'b0;
        end else begin
            tmr_cnt_q   <= tmr_cnt_d;
            tmr_pulse_q <= tmr_pulse_d;
        end
    end

    // ==========================================================
    // Sync input synchroniser; the second and third stages feed the edge detector
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
        end else begin
            sync1_q <= sync_in_line_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end
    // A 120 ns pulse spans at least two clock edges, so it is never missed
    assign sync_edge = sync2_q && !sync3_q;                                                  // R10

    // ==========================================================
    // Burst sequencer
    // Accept only from idle, in burst mode, with the buffer enabled
    assign accept = (state_q == BST_IDLE) && burst_en_q && buffer_enabled_in &&              // R13
                    (sw_trig_req || tmr_pulse_q || sync_edge);                               // R9
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        done_d  = 1'b0;
        case (state_q)
            BST_IDLE: begin
                if (accept) begin
                    state_d = BST_RUN;                                                       // R6
                    cnt_d   = '0;
                end
            end
            BST_RUN: begin
                // Losing burst mode or the buffer stops any burst, endless or not
                if (!burst_en_q || !buffer_enabled_in) begin
                    state_d = BST_IDLE;                                                      // R8
                end else if (sample_tick_in) begin
                    cnt_d = cnt_q + BLEN_W'(1);
                    // Zero length never matches, so the burst runs on
                    if ((blen_q != '0) && (cnt_d == blen_q)) begin
                        state_d = BST_IDLE;                                                  // R24
                        done_d  = 1'b1;                                                      // R6
                    end
                end
            end
            default: state_d = BST_IDLE;
        endcase
        samp_en_d = (state_d == BST_RUN);
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q   <= BST_IDLE;
            cnt_q     <= '0;
            done_q    <= 1'b0;
            samp_en_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            cnt_q     <= cnt_d;
            done_q    <= done_d;
            samp_en_q <= samp_en_d;
        end
    end

    // ==========================================================
    // Trigger echo and normal board sync
    always_comb begin
        echo_cnt_d = echo_cnt_q;
        if (accept) begin
            echo_cnt_d = ECHO_LOAD;                                                          // R12
        end else if (echo_cnt_q != '0) begin
            echo_cnt_d = echo_cnt_q - 2'h1;
        end
        echo_d = (echo_cnt_d != '0);
        // Burst mode takes the sync line and the sync command away from synchronisation
        bsync_d = !burst_en_q && (sync_edge || sw_sync_req);                                 // R15 R17
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            echo_cnt_q <= '0;
            echo_q     <= 1'b0;
            bsync_q    <= 1'b0;
        end else begin
            echo_cnt_q <= echo_cnt_d;
            echo_q     <= echo_d;
            bsync_q    <= bsync_d;
        end
    end

    // ==========================================================
    // Outputs, all straight from flops
    assign rdata_out          = rdata_q;
    assign sync_out_line_out  = echo_q;
    assign ipc_out            = ipc_q;
    assign channels_ready_out = ready_q;
    assign sample_enable_out  = samp_en_q;
    assign burst_done_out     = done_q;
    assign burst_total_out    = total_q;
    assign board_sync_out     = bsync_q;

    // ==========================================================
    // Assertions
    property p_echo_width;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        $rose(sync_out_line_out) |-> sync_out_line_out [*3] ##1 !sync_out_line_out;
    endproperty
    a_echo_width: assert property (p_echo_width) else $error("Echo pulse not three cycles"); // R12

    property p_echo_on_accept;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == BST_IDLE && state_d == BST_RUN) |=> sync_out_line_out && sample_enable_out;
    endproperty
    a_echo_on_accept: assert property (p_echo_on_accept) else $error("Trigger not echoed"); // R12

    property p_busy_ignores;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == BST_RUN) |=> !$rose(sync_out_line_out);
    endproperty
    a_busy_ignores: assert property (p_busy_ignores) else $error("Trigger taken while busy"); // R13

    property p_buffer_off;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !buffer_enabled_in |=> (state_q == BST_IDLE) && !sample_enable_out;
    endproperty
    a_buffer_off: assert property (p_buffer_off) else $error("Burst with buffer disabled"); // R13

    property p_trig_readback;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (lbus_in.rd && lbus_in.addr == OFS_BCR) |=> rdata_out[BCR_SW_TRIG] == $past(samp_en_q);
    endproperty
    a_trig_readback: assert property (p_trig_readback) else $error("Trigger bit readback wrong"); // R11

    property p_finite_end;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == BST_RUN && burst_en_q && buffer_enabled_in && sample_tick_in &&
         blen_q != '0 && cnt_q + BLEN_W'(1) == blen_q) |=> burst_done_out && !sample_enable_out;
    endproperty
    a_finite_end: assert property (p_finite_end) else $error("Finite burst did not end"); // R24

    property p_endless;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (state_q == BST_RUN && blen_q == '0 && burst_en_q && buffer_enabled_in) |=> state_q == BST_RUN;
    endproperty
    a_endless: assert property (p_endless) else $error("Endless burst stopped"); // R8

    property p_timer_restart;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        tmr_pulse_q |-> tmr_cnt_q == '0;
    endproperty
    a_timer_restart: assert property (p_timer_restart) else $error("Timer did not restart"); // R25

    property p_settle_hold;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        settle_start |=> !channels_ready_out [*8];
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("Ready not held low"); // R5

    property p_no_sync_in_burst;
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (burst_en_q && (sync_edge || sw_sync_req)) |=> !board_sync_out;
    endproperty
    a_no_sync_in_burst: assert property (p_no_sync_in_burst) else $error("Sync in burst mode"); // R15

endmodule

//--- bac_sync_partner.sv
// Far-side model: another board driving the sync input line
`timescale 1ns/1ns
module bac_sync_partner (
    input  wire logic clk_in,        // Core clock
    output logic      sync_line_out  // Sync input pin of the block
);
    // Line rests low between pulses
    initial sync_line_out = 1'b0;
    // Whole-cycle pulse; three cycles give 150 ns, above the least width
    task automatic pulse(input int n);
        @(negedge clk_in);
        sync_line_out = 1'b1;
        repeat (n) @(negedge clk_in);
        sync_line_out = 1'b0;
    endtask
endmodule

//--- tb_burst_acquisition_control.sv
// Self-checking bench for the burst acquisition control block
`timescale 1ns/1ns
module tb_burst_acquisition_control;
    import bac_pkg::*;
    // ==========================================================
    // Signals and model state
    localparam int SETTLE = 20;            // Short settling hold
    logic core_clk_in = 0, reset_n_in = 0, buf_en = 1, tick_s = 0, sync_l, s_out, rdy, sen, done, bsync;
    bac_lbus_s lbus = '0;                  // Register bus request
    logic [CHN_W-1:0] chans = 4'h1;        // Active channels
    logic [DATA_W-1:0] rdata;              // Read data
    bac_ipc_s ipc;                         // Port configuration
    logic [TOT_W-1:0] total;               // Burst total
    logic echo_q = 0;                      // Echo delayed for edges
    int fail_count = 0, comparisons = 0, cyc = 0, echo_n = 0, hi_n = 0, done_n = 0, bs_n = 0, bl, d, t0;
    bac_burst_ctrl #(.SETTLE_CYCLES(SETTLE)) DUT (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .lbus_in(lbus), .rdata_out(rdata), .buffer_enabled_in(buf_en), .sample_tick_in(tick_s),
        .active_channels_in(chans), .sync_in_line_in(sync_l), .sync_out_line_out(s_out), .ipc_out(ipc),
        .channels_ready_out(rdy), .sample_enable_out(sen), .burst_done_out(done), .burst_total_out(total),
        .board_sync_out(bsync));
    bac_sync_partner P (.clk_in(core_clk_in), .sync_line_out(sync_l));
    initial forever #25 core_clk_in = ~core_clk_in;
    // ==========================================================
    // Pulse counters and hang guard
    always @(posedge core_clk_in) begin
        cyc++;
        echo_q <= s_out;
        if (s_out === 1'b1 && echo_q === 1'b0) echo_n++;
        if (s_out === 1'b1) hi_n++;
        if (done === 1'b1) done_n++;
        if (bsync === 1'b1) bs_n++;
        if (cyc > 20000) begin
            fail_count++;
            conclude();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic conclude();
        if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Bus strobes last one cycle; a new call waits for the next falling edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(negedge core_clk_in) lbus = '{1'b1, 1'b0, a, v};
        @(negedge core_clk_in) lbus = '0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        @(negedge core_clk_in) lbus = '{1'b0, 1'b1, a, 32'h0};
        @(negedge core_clk_in) lbus = '0;
        @(negedge core_clk_in) chk(nm, e, rdata);
    endtask
    task automatic cy(input int n);
        repeat (n) @(negedge core_clk_in);
    endtask
    task automatic tk(input int n);
        repeat (n) begin
            @(negedge core_clk_in) tick_s = 1'b1;
            @(negedge core_clk_in) tick_s = 1'b0;
        end
    endtask
    task automatic wait_echo();
        int n0 = echo_n;
        for (int i = 0; i < 200 && echo_n == n0; i++) @(negedge core_clk_in);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(15914));
        cy(5);
        reset_n_in = 1'b1;
        rdc("bcr", OFS_BCR, 32'h0);
        rdc("ipc", OFS_IPC, 32'h0);
        rdc("blen", OFS_BLEN, 32'h1);
        rdc("timer", OFS_TMR, 32'h0000C000);
        rdc("unmapped", 8'h04, 32'h0);
        cy(SETTLE);
        rdc("ready", OFS_BCR, 32'h00002000);
        d = ($urandom & 7) | 2;
        wr(OFS_IPC, d);
        cy(2);
        chk("ipc_out", d, ipc);
        chk("hold", 0, rdy);
        cy(SETTLE);
        chk("settled", 1, rdy);
        wr(OFS_IPC, 32'h1);
        cy(3);
        chk("no hold", 1, rdy);
        chans = 1 + $urandom_range(11);
        bl = 2 + $urandom_range(5);
        wr(OFS_BLEN, bl);
        wr(OFS_BCR, 32'h00200000);
        wr(OFS_BCR, 32'h00600000);
        cy(5);
        chk("echo", 1, echo_n);
        chk("total", bl * chans, total);
        wr(OFS_BCR, 32'h00600000);
        wr(OFS_BCR, 32'h00200000);
        rdc("busy", OFS_BCR, 32'h00602000);
        tk(bl - 1);
        chk("gate", 1, sen);
        tk(1);
        cy(2);
        chk("done", 1, done_n);
        rdc("idle", OFS_BCR, 32'h00202000);
        buf_en = 1'b0;
        wr(OFS_BCR, 32'h00600000);
        cy(4);
        chk("buf off", 1, echo_n);
        buf_en = 1'b1;
        wr(OFS_BCR, 32'h0);
        P.pulse(3);
        cy(5);
        chk("sync", 1, bs_n);
        wr(OFS_BCR, 32'h00200000);
        wr(OFS_BCR, 32'h00200040);
        P.pulse(3);
        cy(5);
        chk("sync trig", 2, echo_n);
        chk("no sync", 1, bs_n);
        tk(bl);
        wr(OFS_BLEN, 32'h0);
        wr(OFS_BCR, 32'h00600000);
        tk(bl + 4);
        chk("endless", 1, sen);
        wr(OFS_BCR, 32'h0);
        cy(3);
        chk("abort", 0, sen);
        wr(OFS_BLEN, 32'h1);
        d = 10 + $urandom_range(10);
        wr(OFS_TMR, d);
        tick_s = 1'b1;
        wr(OFS_BCR, 32'h00210000);
        wait_echo();
        t0 = cyc;
        wait_echo();
        chk("period", d, cyc - t0);
        tick_s = 1'b0;
        wr(OFS_BCR, 32'h0);
        cy(4);
        chk("width", SYNC_OUT_CYC * echo_n, hi_n);
        conclude();
    end
endmodule
